// ### oled_module_host_interface_tb_top.sv
/* Bench joining host and display ends through omhi_if.
   Assumes package, bundle, both ends and checker compile first. */
`timescale 1ns/1ns
`default_nettype none
module oled_module_host_interface_tb_top;
    logic clk, rst_n = 1'h0, holdReset = 1'h0, reqValid = 1'h0, reqRead = 1'h0;
    logic reqIsData = 1'h0, reqReady, rspValid, rxValid, rxIsData, readReq;
    logic [1:0] modeSel = 2'h0, hostMode;
    logic [7:0] reqByte = 8'h00, rspByte, rxByte;
    logic [11:0] t;
    // Tests as {mode, read, data flag, byte}
    logic [11:0] tbl [7] = '{12'h5a5, 12'hc3c, 12'h196, 12'h85a, 12'h200, 12'h6c5, 12'hec5};
    int errorCnt, samplesChecked, cycles, reads;
    // Bundle, both ends and the pin checker
    omhi_if pins ();
    omhi_host i_omhi_host (.clk, .rst_n, .bus(pins.host), .modeSel, .holdReset, .reqValid,
        .reqRead, .reqIsData, .reqByte, .reqReady, .rspValid, .rspByte);
    omhi_device i_omhi_device (.clk, .rst_n, .bus(pins.device), .readByte(8'hc5), .rxValid,
        .rxByte, .rxIsData, .readReq, .hostMode);
    omhi_monitor i_omhi_monitor (.clk, .rst_n, .busSelectStrapA(pins.busSelectStrapA),
        .busSelectStrapB(pins.busSelectStrapB), .chipSelectN(pins.chipSelectN),
        .resetNInput(pins.resetNInput), .readWriteSel(pins.readWriteSel),
        .enableStrobe(pins.enableStrobe), .hostDataOe(pins.hostDataOe),
        .devDataOe(pins.devDataOe));
    // Free running clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
        if (++cycles == 40000)
        begin
            errorCnt++;
            finalReport();
        end
    // Read cycles the display end reports
    always @(posedge clk)
        if (readReq === 1'h1)
            reads++;
    // Compare and count
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Counts and verdict
    task automatic finalReport();
        $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
        if (errorCnt == 0 && samplesChecked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finalReport
    // One request, then wait for its byte
    task automatic xfer(input logic rd, input logic dc, input logic [7:0] b);
        int n = 0;
        do @(posedge clk); while (reqReady !== 1'h1 && ++n < 200);
        reqValid <= 1'h1;
        reqRead <= rd;
        reqIsData <= dc;
        reqByte <= b;
        @(posedge clk);
        reqValid <= 1'h0;
        do @(posedge clk); while ((rd ? rspValid : rxValid) !== 1'h1 && ++n < 20000);
        if (n >= 20000)
            errorCnt++;
    endtask : xfer
    // Each mode from reset, then module reset pin
    initial
    begin
        foreach (tbl[i])
        begin
            t = tbl[i];
            rst_n <= 1'h0;
            modeSel <= t[11:10];
            repeat (4) @(posedge clk);
            rst_n <= 1'h1;
            repeat (30) @(posedge clk);
            check("mode", 9'(hostMode), 9'(t[11:10]));
            // Reads send the complement, so only the display end can supply the byte
            xfer(t[9], t[8], t[7:0] ^ {8{t[9]}});
            check("rx", t[9] ? {1'b0, rspByte} : {rxIsData, rxByte}, t[8:0]);
            $display("test %0d done", i);
        end
        xfer(1'h0, 1'h1, 8'h81);
        check("rx", {rxIsData, rxByte}, 9'h181);
        check("reads", 9'(reads), 9'h002);
        $display("test write done");
        holdReset <= 1'h1;
        repeat (20) @(posedge clk);
        holdReset <= 1'h0;
        repeat (30) @(posedge clk);
        check("cleared", {rxIsData, rxByte}, 9'h000);
        $display("test reset done");
        finalReport();
    end
endmodule : oled_module_host_interface_tb_top
`default_nettype wire

// ### omhi_device.sv
/*
 * Display module end of the host port: decodes the strap mode and takes
 * bytes from 68-style, 80-style, serial or I2C hosts.
 * Assumes pins are asynchronous to clk; the user side holds readByte
 * steady while a read cycle is open.
 */
`timescale 1ns/1ns
`default_nettype none
module omhi_device #(
    parameter logic [6:0] SLAVE_ADDR = omhi_pkg::I2C_ADDR
) (
    input wire logic clk,
    input wire logic rst_n,
    omhi_if.device bus,
    input wire logic [7:0] readByte,
    output logic rxValid,
    output logic [7:0] rxByte,
    output logic rxIsData,
    output logic readReq,
    output logic [1:0] hostMode
);
    typedef enum logic [1:0] {
        I2C_IDLE,
        I2C_ADDR_ST,
        I2C_CTRL,
        I2C_DATA
    } omhi_i2c_state_type;

    typedef struct packed {
        logic [omhi_pkg::PIN_W-1:0] s1;
        logic [omhi_pkg::PIN_W-1:0] s2;
        logic [omhi_pkg::PIN_W-1:0] s3;
        logic [omhi_pkg::PIN_W-1:0] filt;
        logic [omhi_pkg::PIN_W-1:0] prev;
        omhi_i2c_state_type i2cSt;
        logic [7:0] shift;
        logic [3:0] bitCnt;
        logic ctlDc;
        logic armed;
        logic [7:0] dataOut;
        logic [7:0] dataOe;
        logic rxValid;
        logic [7:0] rxByte;
        logic rxIsData;
        logic readReq;
        logic [1:0] hostMode;
    } omhi_dev_state_type;

    omhi_dev_state_type st;
    omhi_dev_state_type next_st;

    logic [omhi_pkg::PIN_W-1:0] pinsIn;
    logic [omhi_pkg::PIN_W-1:0] filtNext;
    logic [omhi_pkg::PIN_W-1:0] rise;
    logic [omhi_pkg::PIN_W-1:0] fall;
    logic [1:0] mode;
    logic csOn;
    logic p68;
    logic p80;
    logic rdStart;
    logic wrStart;
    logic rdEnd;
    logic wrEnd;
    logic sclHi;
    logic i2cStart;
    logic i2cStop;
    logic [7:0] serByte;

    // Pin vector in package bit order
    assign pinsIn = {bus.busSelectStrapB, bus.busSelectStrapA, bus.resetNInput,
        bus.chipSelectN, bus.enableStrobe, bus.readWriteSel, bus.dataCmdSel,
        bus.hostDataBus};

    // A pin change counts once stages two and three agree
    assign filtNext = (st.s2 & st.s3) | (st.filt & (st.s2 | st.s3));
    assign rise = st.filt & ~st.prev;
    assign fall = ~st.filt & st.prev;

    // Mode from the straps and chip select gating
    assign mode = {st.filt[omhi_pkg::P_BSA], st.filt[omhi_pkg::P_BSB]}; // see R01
    assign csOn = ~st.filt[omhi_pkg::P_CS]; // see R02
    assign p68 = (mode == omhi_pkg::MODE_P68);
    assign p80 = (mode == omhi_pkg::MODE_P80);

    // Parallel cycle starts and ends per bus style
    assign rdStart = csOn & ((p68 & rise[omhi_pkg::P_EN] & st.filt[omhi_pkg::P_RW]) // see R05
        | (p80 & fall[omhi_pkg::P_EN])); // see R06
    assign wrStart = csOn & ((p68 & rise[omhi_pkg::P_EN] & ~st.filt[omhi_pkg::P_RW]) // see R11
        | (p80 & fall[omhi_pkg::P_RW])); // see R07
    assign rdEnd = (p68 & fall[omhi_pkg::P_EN]) | (p80 & rise[omhi_pkg::P_EN]) | ~csOn;
    assign wrEnd = (p68 & fall[omhi_pkg::P_EN]) | (p80 & rise[omhi_pkg::P_RW]);

    // I2C start and stop: SDA moves while SCL stays high
    assign sclHi = st.filt[omhi_pkg::P_SCL] & st.prev[omhi_pkg::P_SCL];
    assign i2cStart = csOn & sclHi & fall[omhi_pkg::P_SDI]; // see R10
    assign i2cStop = sclHi & rise[omhi_pkg::P_SDI];
    assign serByte = {st.shift[6:0], st.filt[omhi_pkg::P_SDI]};

    // Next state of the whole end
    always_comb
    begin
        next_st = st;
        next_st.s1 = pinsIn;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.filt = filtNext;
        next_st.prev = st.filt;
        next_st.rxValid = 1'h0;
        next_st.readReq = 1'h0;
        next_st.hostMode = mode;

        case (mode)
            omhi_pkg::MODE_P68, omhi_pkg::MODE_P80:
            begin
                // Drive the bus only inside a read cycle
                if (rdStart)
                begin
                    next_st.dataOut = readByte; // see R08
                    next_st.dataOe = 8'hff;
                    next_st.readReq = 1'h1;
                end
                else if (rdEnd)
                begin
                    next_st.dataOe = 8'h00; // see R08
                end
                // Write byte taken at the strobe's trailing edge
                if (!csOn)
                begin
                    next_st.armed = 1'h0; // see R02
                end
                else if (wrStart)
                begin
                    next_st.armed = 1'h1;
                end
                else if (wrEnd && st.armed)
                begin
                    next_st.armed = 1'h0;
                    next_st.rxValid = 1'h1;
                    next_st.rxByte = st.filt[7:0];
                    next_st.rxIsData = st.filt[omhi_pkg::P_DC]; // see R04
                end
            end
            omhi_pkg::MODE_SERIAL:
            begin
                next_st.dataOe = 8'h00;
                if (!csOn)
                begin
                    next_st.bitCnt = 4'h0; // see R02
                end
                else if (rise[omhi_pkg::P_SCL]) // see R09
                begin
                    next_st.shift = serByte; // see R12
                    if (st.bitCnt == omhi_pkg::BYTE_LAST_BIT)
                    begin
                        next_st.bitCnt = 4'h0;
                        next_st.rxValid = 1'h1;
                        next_st.rxByte = serByte;
                        next_st.rxIsData = st.filt[omhi_pkg::P_DC]; // see R04
                    end
                    else
                    begin
                        next_st.bitCnt = st.bitCnt + 4'h1;
                    end
                end
            end
            default:
            begin
                // I2C: address, control byte, then data bytes
                if (i2cStart)
                begin
                    next_st.i2cSt = I2C_ADDR_ST;
                    next_st.bitCnt = 4'h0;
                    next_st.dataOe = 8'h00;
                end
                else if (i2cStop)
                begin
                    next_st.i2cSt = I2C_IDLE;
                    next_st.dataOe = 8'h00;
                end
                else if (st.i2cSt != I2C_IDLE)
                begin
                    if (rise[omhi_pkg::P_SCL] && st.bitCnt < omhi_pkg::ACK_SLOT)
                    begin
                        next_st.shift = serByte; // see R10
                        next_st.bitCnt = st.bitCnt + 4'h1;
                    end
                    else if (fall[omhi_pkg::P_SCL] && st.bitCnt == omhi_pkg::ACK_SLOT)
                    begin
                        // Acknowledge a matching address and each later byte by pulling the data output low
                        next_st.bitCnt = omhi_pkg::ACK_DONE;
                        next_st.dataOut = 8'h00;
                        next_st.dataOe[omhi_pkg::P_SDO] = 1'h1;
                        case (st.i2cSt)
                            I2C_ADDR_ST:
                            begin
                                if (st.shift == {SLAVE_ADDR, 1'h0})
                                begin
                                    next_st.i2cSt = I2C_CTRL;
                                end
                                else
                                begin
                                    next_st.i2cSt = I2C_IDLE;
                                    next_st.dataOe = 8'h00;
                                end
                            end
                            I2C_CTRL:
                            begin
                                next_st.ctlDc = st.shift[omhi_pkg::CTRL_DC_BIT];
                                next_st.i2cSt = I2C_DATA;
                            end
                            default:
                            begin
                                next_st.rxValid = 1'h1;
                                next_st.rxByte = st.shift;
                                next_st.rxIsData = st.ctlDc;
                            end
                        endcase
                    end
                    else if (fall[omhi_pkg::P_SCL] && st.bitCnt == omhi_pkg::ACK_DONE)
                    begin
                        next_st.bitCnt = 4'h0;
                        next_st.dataOe = 8'h00;
                    end
                end
            end
        endcase

        // Reset pin low: all but the pin synchronisers to defaults
        if (!st.filt[omhi_pkg::P_MRST])
        begin
            next_st = '0; // see R03
            next_st.s1 = pinsIn;
            next_st.s2 = st.s1;
            next_st.s3 = st.s2;
            next_st.filt = filtNext;
            next_st.prev = st.filt;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign bus.devDataOut = st.dataOut;
    assign bus.devDataOe = st.dataOe;
    assign rxValid = st.rxValid;
    assign rxByte = st.rxByte;
    assign rxIsData = st.rxIsData;
    assign readReq = st.readReq;
    assign hostMode = st.hostMode;
endmodule : omhi_device
`default_nettype wire

// ### omhi_host.sv
/*
 * Host end of the display module port: runs one byte transfer per
 * write, and per read on the parallel bus, in the mode its straps select.
 * Assumes modeSel is static and the display end answers through omhi_if.
 */
`timescale 1ns/1ns
`default_nettype none
module omhi_host #(
    parameter logic [6:0] SLAVE_ADDR = omhi_pkg::I2C_ADDR
) (
    input wire logic clk,
    input wire logic rst_n,
    omhi_if.host bus,
    input wire logic [1:0] modeSel,
    input wire logic holdReset,
    input wire logic reqValid,
    input wire logic reqRead,
    input wire logic reqIsData,
    input wire logic [7:0] reqByte,
    output logic reqReady,
    output logic rspValid,
    output logic [7:0] rspByte
);
    typedef enum logic [2:0] {
        H_IDLE,
        H_SETUP,
        H_STROBE,
        H_HOLD,
        H_START,
        H_BITLO,
        H_BITHI,
        H_STOP
    } omhi_host_state_type;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] filt;
        omhi_host_state_type st;
        logic [7:0] tmr;
        logic [26:0] frame;
        logic [4:0] bits;
        logic isRead;
        logic [1:0] straps;
        logic csN;
        logic resN;
        logic dc;
        logic rw;
        logic en;
        logic [7:0] dOut;
        logic [7:0] dOe;
        logic reqReady;
        logic rspValid;
        logic [7:0] rspByte;
    } omhi_host_regs_type;

    omhi_host_regs_type st;
    omhi_host_regs_type next_st;
    logic isI2c;
    logic isP80;
    logic parallel;
    logic done;
    logic [7:0] halfCyc;

    assign isI2c = (st.straps == omhi_pkg::MODE_I2C);
    assign isP80 = (st.straps == omhi_pkg::MODE_P80);
    assign parallel = isP80 || (st.straps == omhi_pkg::MODE_P68);
    assign done = (st.tmr == 8'h00);
    assign halfCyc = isI2c ? omhi_pkg::I2C_PHASE_CYC : omhi_pkg::SER_PHASE_CYC;

    // Next state of the host
    always_comb
    begin
        next_st = st;
        next_st.s1 = bus.hostDataBus;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 | st.s3));
        next_st.straps = modeSel; // see R01
        next_st.resN = ~holdReset; // see R03
        next_st.rspValid = 1'h0;
        if (!done)
        begin
            next_st.tmr = st.tmr - 8'h01;
        end
        case (st.st)
            H_IDLE:
            begin
                next_st.reqReady = 1'h1;
                next_st.en = isP80;
                next_st.rw = 1'h1;
                if (reqValid && st.reqReady && reqRead && !parallel)
                begin
                    // Reads exist only on the parallel bus
                    next_st.rspValid = 1'h1;
                    next_st.rspByte = 8'h00;
                end
                else if (reqValid && st.reqReady)
                begin
                    next_st.reqReady = 1'h0;
                    next_st.csN = 1'h0; // see R02
                    next_st.dc = reqIsData; // see R04
                    next_st.isRead = reqRead;
                    if (parallel)
                    begin
                        next_st.rw = isP80 | reqRead; // see R11
                        next_st.dOut = reqByte;
                        next_st.dOe = reqRead ? 8'h00 : 8'hff;
                        next_st.st = H_SETUP;
                        next_st.tmr = omhi_pkg::PAR_PHASE_CYC;
                    end
                    else if (isI2c)
                    begin
                        // Start: SDA falls with SCL high
                        next_st.frame = {SLAVE_ADDR, 1'h0, 1'h1, 1'h0, reqIsData, 6'h00,
                            1'h1, reqByte, 1'h1};
                        next_st.bits = omhi_pkg::I2C_FRAME_BITS;
                        next_st.dOut = 8'h01;
                        next_st.dOe = 8'h03; // see R10
                        next_st.st = H_START;
                        next_st.tmr = omhi_pkg::I2C_PHASE_CYC;
                    end
                    else
                    begin
                        next_st.frame = {reqByte, 19'h0_0000};
                        next_st.bits = omhi_pkg::SER_FRAME_BITS;
                        next_st.dOut = 8'h00;
                        next_st.dOe = 8'h03; // see R09
                        next_st.st = H_BITLO;
                        next_st.tmr = omhi_pkg::SER_PHASE_CYC;
                    end
                end
            end
            H_SETUP:
            begin
                if (done)
                begin
                    if (!isP80)
                    begin
                        next_st.en = 1'h1; // see R05
                    end
                    else if (st.isRead)
                    begin
                        next_st.en = 1'h0; // see R06
                    end
                    else
                    begin
                        next_st.rw = 1'h0; // see R07
                    end
                    next_st.st = H_STROBE;
                    next_st.tmr = omhi_pkg::PAR_PHASE_CYC;
                end
            end
            H_STROBE:
            begin
                if (done)
                begin
                    if (st.isRead)
                    begin
                        next_st.rspValid = 1'h1;
                        next_st.rspByte = st.filt;
                    end
                    next_st.en = isP80;
                    next_st.rw = isP80 | st.rw;
                    next_st.st = H_HOLD;
                    next_st.tmr = omhi_pkg::PAR_PHASE_CYC;
                end
            end
            H_HOLD:
            begin
                if (done)
                begin
                    next_st.csN = 1'h1;
                    next_st.dOe = 8'h00;
                    next_st.st = H_IDLE;
                end
            end
            H_START:
            begin
                if (done)
                begin
                    next_st.dOut[omhi_pkg::P_SCL] = 1'h0;
                    next_st.st = H_BITLO;
                    next_st.tmr = halfCyc;
                end
            end
            H_BITLO:
            begin
                // Data moves mid-way through SCL low
                if (st.tmr == (halfCyc >> 1))
                begin
                    next_st.dOut[omhi_pkg::P_SDI] = isI2c ? 1'h0 : st.frame[26];
                    next_st.dOe[omhi_pkg::P_SDI] = ~isI2c | ~st.frame[26];
                end
                if (done)
                begin
                    next_st.dOut[omhi_pkg::P_SCL] = 1'h1; // see R12
                    next_st.st = H_BITHI;
                    next_st.tmr = halfCyc;
                end
            end
            H_BITHI:
            begin
                if (done)
                begin
                    next_st.dOut[omhi_pkg::P_SCL] = 1'h0;
                    next_st.frame = {st.frame[25:0], 1'h0};
                    next_st.bits = st.bits - 5'h01;
                    next_st.tmr = halfCyc;
                    if (st.bits != 5'h01)
                    begin
                        next_st.st = H_BITLO;
                    end
                    else if (isI2c)
                    begin
                        next_st.dOut[omhi_pkg::P_SDI] = 1'h0;
                        next_st.dOe[omhi_pkg::P_SDI] = 1'h1;
                        next_st.st = H_STOP;
                    end
                    else
                    begin
                        next_st.st = H_HOLD;
                    end
                end
            end
            H_STOP:
            begin
                // Stop: SCL rises, then SDA is released
                if (st.tmr == (halfCyc >> 1))
                begin
                    next_st.dOut[omhi_pkg::P_SCL] = 1'h1;
                end
                if (done)
                begin
                    next_st.dOe[omhi_pkg::P_SDI] = 1'h0;
                    next_st.st = H_HOLD;
                    next_st.tmr = halfCyc;
                end
            end
            default:
            begin
                next_st.st = H_IDLE;
            end
        endcase
    end

    // State register; chip select and write strobe idle high
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.csN <= 1'h1;
            st.rw <= 1'h1;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Pins and user outputs from the state register
    assign bus.busSelectStrapA = st.straps[1];
    assign bus.busSelectStrapB = st.straps[0];
    assign bus.chipSelectN = st.csN;
    assign bus.resetNInput = st.resN;
    assign bus.dataCmdSel = st.dc;
    assign bus.readWriteSel = st.rw;
    assign bus.enableStrobe = st.en;
    assign bus.hostDataOut = st.dOut;
    assign bus.hostDataOe = st.dOe;
    assign reqReady = st.reqReady;
    assign rspValid = st.rspValid;
    assign rspByte = st.rspByte;
endmodule : omhi_host
`default_nettype wire

// ### omhi_if.sv
/*
 * Pin bundle between host and display module.
 * Resolves the data bus: open lines pull high; in I2C mode bits 2 and 1
 * form one wired-AND SDA line.
 */
`timescale 1ns/1ns
`default_nettype none
interface omhi_if;
    logic busSelectStrapA;
    logic busSelectStrapB;
    logic chipSelectN;
    logic resetNInput;
    logic dataCmdSel;
    logic readWriteSel;
    logic enableStrobe;
    logic [7:0] hostDataOut;
    logic [7:0] hostDataOe;
    logic [7:0] devDataOut;
    logic [7:0] devDataOe;
    logic [7:0] hostDataBus;
    logic [7:0] level;
    logic i2cMode;
    logic sdaLow;

    // Driven value wins, else pull-up
    assign level = (devDataOe & devDataOut) | (~devDataOe & hostDataOe & hostDataOut)
        | (~devDataOe & ~hostDataOe);
    assign i2cMode = busSelectStrapA & ~busSelectStrapB;
    // SDA low when either end pulls its side low
    assign sdaLow = (hostDataOe[1] & ~hostDataOut[1]) | (devDataOe[2] & ~devDataOut[2]);
    assign hostDataBus = i2cMode ? {level[7:3], ~sdaLow, ~sdaLow, level[0]} : level;

    modport device (
        input busSelectStrapA, busSelectStrapB, chipSelectN, resetNInput,
        input dataCmdSel, readWriteSel, enableStrobe, hostDataBus,
        output devDataOut, devDataOe
    );
    modport host (
        output busSelectStrapA, busSelectStrapB, chipSelectN, resetNInput,
        output dataCmdSel, readWriteSel, enableStrobe, hostDataOut, hostDataOe,
        input hostDataBus
    );
endinterface : omhi_if
`default_nettype wire

// ### omhi_monitor.sv
/* Pin checker for the omhi_if bundle.
   Assumes one clock; sees only the bundle's signals and rst_n. */
`timescale 1ns/1ns
`default_nettype none
module omhi_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic busSelectStrapA,
    input wire logic busSelectStrapB,
    input wire logic chipSelectN,
    input wire logic resetNInput,
    input wire logic readWriteSel,
    input wire logic enableStrobe,
    input wire logic [7:0] hostDataOe,
    input wire logic [7:0] devDataOe
);
    // Mode decode from the straps
    wire logic p68 = !busSelectStrapA && busSelectStrapB;
    wire logic p80 = busSelectStrapA && busSelectStrapB;
    wire logic ser = !busSelectStrapA && !busSelectStrapB;
    wire logic i2c = busSelectStrapA && !busSelectStrapB;
    // Pin rules, all on clk
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_cs_quiet: assert property (chipSelectN [*8] |-> !devDataOe)
        else $error("bus driven while deselected");
    chk_res_quiet: assert property (!resetNInput [*8] |-> !devDataOe)
        else $error("bus driven in reset");
    chk_wr_quiet: assert property ((p68 && !readWriteSel) [*8] |-> !devDataOe)
        else $error("bus driven on write");
    chk_ser_quiet: assert property (ser [*8] |-> !devDataOe)
        else $error("bus driven in serial");
    chk_i2c_pins: assert property (i2c [*8] |-> !(devDataOe & 8'hfb))
        else $error("wrong i2c pin driven");
    chk_rd_release: assert property (p80 && !enableStrobe && !chipSelectN |-> !hostDataOe)
        else $error("host drives during read");
    chk_strobe_excl: assert property (p80 && !chipSelectN |-> readWriteSel || enableStrobe)
        else $error("both strobes low");
    chk_en_setup: assert property ($rose(enableStrobe) && p68 |->
        !chipSelectN && $stable(readWriteSel))
        else $error("enable rose unprepared");
endmodule : omhi_monitor
`default_nettype wire

// ### omhi_pkg.sv
/*
 * Shared constants of the display module host port: mode codes, pin
 * positions and phase timing for both ends.
 * Assumes both ends run on one 125 MHz clock and meet through omhi_if.
 */
// Notes on behaviour
// R01 - Two straps pick the host interface mode
// R02 - Chip select low gates every host access
// R03 - Reset pin low returns logic to defaults
// R04 - Data/command pin high means data, low command
// R05 - 68 mode: enable rising starts a cycle
// R06 - 80 mode: read strobe low starts read
// R07 - 80 mode: write strobe low begins write
// R08 - Eight-bit bus, device drives only reads
// R09 - Serial: bit 1 data in, bit 0 clock
// R10 - I2C: bits 2,1 form SDA, 0 SCL
// R11 - 68 mode: read/write set before enable rises
// R12 - Serial: rising clock, MSB first, eight bits
`default_nettype none
package omhi_pkg;
    // Mode codes, formed as {strap a, strap b}
    localparam logic [1:0] MODE_SERIAL = 2'h0;
    localparam logic [1:0] MODE_P68 = 2'h1;
    localparam logic [1:0] MODE_I2C = 2'h2;
    localparam logic [1:0] MODE_P80 = 2'h3;

    // Bit positions in the device's synchronised pin vector
    localparam int PIN_W = 15;
    localparam int P_SCL = 0;
    localparam int P_SDI = 1;
    localparam int P_SDO = 2;
    localparam int P_DC = 8;
    localparam int P_RW = 9;
    localparam int P_EN = 10;
    localparam int P_CS = 11;
    localparam int P_MRST = 12;
    localparam int P_BSA = 13;
    localparam int P_BSB = 14;

    // I2C framing: slave address, data flag in the control byte
    localparam logic [6:0] I2C_ADDR = 7'h3c;
    localparam int CTRL_DC_BIT = 6;
    localparam logic [4:0] I2C_FRAME_BITS = 5'h1b;
    localparam logic [4:0] SER_FRAME_BITS = 5'h08;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] ACK_DONE = 4'h9;

    // Phase timing, least times rounded up to whole cycles
    localparam int CLK_PERIOD_NS = 8;
    localparam int PAR_PHASE_NS = 150;
    localparam int SER_PHASE_NS = 150;
    localparam int I2C_PHASE_NS = 1250;
    localparam logic [7:0] PAR_PHASE_CYC =
        8'((PAR_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] SER_PHASE_CYC =
        8'((SER_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] I2C_PHASE_CYC =
        8'((I2C_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage : omhi_pkg
`default_nettype wire
